// File: verilog/mdu_pkg.sv
// Purpose: Shared constants and types for the multiply/divide unit
// Assumes: Byte-wide special register access from the core, one clock
// Notes: Calculation times are whole system clock periods
package mdu_pkg;

    // Register selector values
    localparam logic [2:0] SEL_OPR0 = 3'h0;
    localparam logic [2:0] SEL_OPR1 = 3'h1;
    localparam logic [2:0] SEL_OPR2 = 3'h2;
    localparam logic [2:0] SEL_OPR3 = 3'h3;
    localparam logic [2:0] SEL_OPR4 = 3'h4;
    localparam logic [2:0] SEL_OPR5 = 3'h5;
    localparam logic [2:0] SEL_STAT = 3'h6;

    localparam int NUM_OPR = 6;

    // Status register fields
    localparam int STAT_ERR_BIT = 7;
    localparam int STAT_OVF_BIT = 6;

    // Reset values
    localparam logic [7:0] OPR_RST = 8'h00;
    localparam logic STAT_FLAG_RST = 1'b0;

    // Calculation times in system clock periods
    localparam logic [4:0] DIV32_PERIODS = 5'h11;
    localparam logic [4:0] DIV16_PERIODS = 5'h09;
    localparam logic [4:0] MUL_PERIODS = 5'h0b;

    localparam logic [15:0] PROD_LIMIT = 16'hffff;

    typedef enum logic [1:0] {
        OP_DIV32,
        OP_DIV16,
        OP_MUL
    } mdu_op_t;

    // Write-order tracker states, named by the registers written so far
    typedef enum logic [3:0] {
        SQ_NONE,
        SQ_R0,
        SQ_R01,
        SQ_R012,
        SQ_R0123,
        SQ_R01234,
        SQ_R014,
        SQ_R04,
        SQ_R041
    } mdu_seq_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [2:0] sel;
        logic [7:0] wdata;
    } mdu_sfr_req_t;

endpackage : mdu_pkg

// File: verilog/mdu_unit.sv
// Purpose: Multiply/divide unit driven by operand write order
// Assumes: Core issues at most one read or write per cycle on sfr_req
// Notes: Results are formed in one step at the end of the fixed time
`timescale 1ns/1ps
`default_nettype none

module mdu_unit (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Special register access from the core
    input wire mdu_pkg::mdu_sfr_req_t sfr_req,
    output logic [7:0] sfr_rdata_ff,
    // State seen by the rest of the chip
    output logic busy_ff,
    output logic access_error_flag_ff,
    output logic overflow_flag_ff
);

    logic [7:0] opr_ff [mdu_pkg::NUM_OPR];
    mdu_pkg::mdu_seq_t seq_ff;
    mdu_pkg::mdu_seq_t nxt_seq;
    mdu_pkg::mdu_op_t op_ff;
    logic [4:0] cnt_ff;
    logic [4:0] start_cnt;

    logic opr_sel;
    logic opr_wr;
    logic opr_rd;
    logic start;
    mdu_pkg::mdu_op_t start_op;
    logic finish;

    logic [31:0] dividend;
    logic [15:0] divisor;
    logic [31:0] quot;
    logic [15:0] rem;
    logic [31:0] prod;
    logic div_zero;
    logic ovf_now;
    logic stat_rd;
    logic busy_acc;
    logic [7:0] stat_byte;

    // Selectors 0 to 5 are operands, 6 is status, 7 is unmapped
    assign opr_sel = (sfr_req.sel <= mdu_pkg::SEL_OPR5);
    assign opr_wr = sfr_req.wr && opr_sel;
    assign opr_rd = sfr_req.rd && opr_sel;
    assign stat_rd = sfr_req.rd && (sfr_req.sel == mdu_pkg::SEL_STAT);
    assign busy_acc = busy_ff && (opr_wr || opr_rd);
    // Last busy cycle; results and the overflow flag land on its closing edge
    assign finish = busy_ff && (cnt_ff == 5'h01);

    // Write-order tracking; reads and other registers leave it alone
    // An idle register zero write always restarts, so a broken order recovers
    always_comb begin
        nxt_seq = seq_ff;
        start = 1'b0;
        start_op = mdu_pkg::OP_DIV32;
        if (opr_wr && !busy_ff) begin
            unique case (sfr_req.sel)
                mdu_pkg::SEL_OPR0: nxt_seq = mdu_pkg::SQ_R0;
                mdu_pkg::SEL_OPR1: begin
                    if (seq_ff == mdu_pkg::SQ_R0) begin
                        nxt_seq = mdu_pkg::SQ_R01;
                    end else if (seq_ff == mdu_pkg::SQ_R04) begin
                        nxt_seq = mdu_pkg::SQ_R041;
                    end else begin
                        nxt_seq = mdu_pkg::SQ_NONE;
                    end
                end
                mdu_pkg::SEL_OPR2: begin
                    nxt_seq = (seq_ff == mdu_pkg::SQ_R01) ? mdu_pkg::SQ_R012
                                                           : mdu_pkg::SQ_NONE;
                end
                mdu_pkg::SEL_OPR3: begin
                    nxt_seq = (seq_ff == mdu_pkg::SQ_R012) ? mdu_pkg::SQ_R0123
                                                            : mdu_pkg::SQ_NONE;
                end
                mdu_pkg::SEL_OPR4: begin
                    if (seq_ff == mdu_pkg::SQ_R0123) begin
                        nxt_seq = mdu_pkg::SQ_R01234;
                    end else if (seq_ff == mdu_pkg::SQ_R01) begin
                        nxt_seq = mdu_pkg::SQ_R014;
                    end else if (seq_ff == mdu_pkg::SQ_R0) begin
                        nxt_seq = mdu_pkg::SQ_R04;
                    end else begin
                        nxt_seq = mdu_pkg::SQ_NONE;
                    end
                end
                mdu_pkg::SEL_OPR5: begin
                    // Any register five write ends the current order
                    nxt_seq = mdu_pkg::SQ_NONE;
                    case (seq_ff)
                        mdu_pkg::SQ_R01234: begin
                            start = 1'b1;
                            start_op = mdu_pkg::OP_DIV32;
                        end
                        mdu_pkg::SQ_R014: begin
                            start = 1'b1;
                            start_op = mdu_pkg::OP_DIV16;
                        end
                        mdu_pkg::SQ_R041: begin
                            start = 1'b1;
                            start_op = mdu_pkg::OP_MUL;
                        end
                        default: begin
                            start = 1'b0;
                        end
                    endcase
                end
                default: nxt_seq = seq_ff;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            seq_ff <= mdu_pkg::SQ_NONE;
        end else begin
            seq_ff <= nxt_seq;
        end
    end

    // Calculation length of the operation about to start
    always_comb begin
        case (start_op)
            mdu_pkg::OP_DIV32: start_cnt = mdu_pkg::DIV32_PERIODS;
            mdu_pkg::OP_DIV16: start_cnt = mdu_pkg::DIV16_PERIODS;
            mdu_pkg::OP_MUL: start_cnt = mdu_pkg::MUL_PERIODS;
            default: start_cnt = mdu_pkg::DIV32_PERIODS;
        endcase
    end

    // Busy spans exactly the calculation time, from the edge after the start
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_ff <= 1'b0;
        end else if (start) begin
            busy_ff <= 1'b1;
        end else if (finish) begin
            busy_ff <= 1'b0;
        end
    end

    // Remaining busy cycles
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= 5'h00;
        end else if (start) begin
            cnt_ff <= start_cnt;
        end else if (busy_ff) begin
            cnt_ff <= cnt_ff - 5'h01;
        end
    end

    // Running operation, held until the next start
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            op_ff <= mdu_pkg::OP_DIV32;
        end else if (start) begin
            op_ff <= start_op;
        end
    end

    // Arithmetic on the operands, which cannot change while busy
    always_comb begin
        divisor = {opr_ff[5], opr_ff[4]};
        if (op_ff == mdu_pkg::OP_DIV32) begin
            dividend = {opr_ff[3], opr_ff[2], opr_ff[1], opr_ff[0]};
        end else begin
            dividend = {16'h0000, opr_ff[1], opr_ff[0]};
        end
        div_zero = (divisor == 16'h0000);
        // Zero divisor gives all-ones quotient and the low 16 bits of the dividend as remainder
        if (div_zero) begin
            quot = 32'hffffffff;
            rem = dividend[15:0];
        end else begin
            quot = dividend / {16'h0000, divisor};
            rem = 16'(dividend % {16'h0000, divisor});
        end
    end

    // Both 16-bit factors are unsigned
    always_comb begin
        prod = {16'h0000, opr_ff[1], opr_ff[0]} * {16'h0000, divisor};
    end

    // Overflow for the operation that is running
    always_comb begin
        if (op_ff == mdu_pkg::OP_MUL) begin
            ovf_now = (prod > {16'h0000, mdu_pkg::PROD_LIMIT});
        end else begin
            ovf_now = div_zero;
        end
    end

    // Operand and result registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < mdu_pkg::NUM_OPR; i++) begin
                opr_ff[i] <= mdu_pkg::OPR_RST;
            end
        end else if (finish) begin
            case (op_ff)
                mdu_pkg::OP_DIV32: begin
                    opr_ff[0] <= quot[7:0];
                    opr_ff[1] <= quot[15:8];
                    opr_ff[2] <= quot[23:16];
                    opr_ff[3] <= quot[31:24];
                    opr_ff[4] <= rem[7:0];
                    opr_ff[5] <= rem[15:8];
                end
                mdu_pkg::OP_DIV16: begin
                    opr_ff[0] <= quot[7:0];
                    opr_ff[1] <= quot[15:8];
                    opr_ff[4] <= rem[7:0];
                    opr_ff[5] <= rem[15:8];
                end
                mdu_pkg::OP_MUL: begin
                    opr_ff[0] <= prod[7:0];
                    opr_ff[1] <= prod[15:8];
                    opr_ff[2] <= prod[23:16];
                    opr_ff[3] <= prod[31:24];
                end
                default: begin
                    opr_ff[0] <= opr_ff[0];
                end
            endcase
        end else if (opr_wr && !busy_ff) begin
            // Writes while busy are dropped so the running operands stay intact
            opr_ff[sfr_req.sel] <= sfr_req.wdata;
        end
    end

    // Status flags
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            access_error_flag_ff <= mdu_pkg::STAT_FLAG_RST;
        end else if (busy_acc) begin
            // Setting takes priority over clearing
            access_error_flag_ff <= 1'b1;
        end else if (stat_rd && !busy_ff) begin
            access_error_flag_ff <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            overflow_flag_ff <= mdu_pkg::STAT_FLAG_RST;
        end else if (finish) begin
            overflow_flag_ff <= ovf_now;
        end
    end

    // Status byte; the unused low bits read as zero
    always_comb begin
        stat_byte = 8'h00;
        stat_byte[mdu_pkg::STAT_ERR_BIT] = access_error_flag_ff;
        stat_byte[mdu_pkg::STAT_OVF_BIT] = overflow_flag_ff;
    end

    // Read data; reads never move the tracker or the results
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sfr_rdata_ff <= 8'h00;
        end else if (sfr_req.rd) begin
            if (opr_sel) begin
                // A busy read shows the live operand and only flags the error
                sfr_rdata_ff <= opr_ff[sfr_req.sel];
            end else if (sfr_req.sel == mdu_pkg::SEL_STAT) begin
                sfr_rdata_ff <= stat_byte;
            end else begin
                sfr_rdata_ff <= 8'h00;
            end
        end
    end

endmodule : mdu_unit

`default_nettype wire

// File: tb/mdu_unit_assertions.sv
// Purpose: Port-level checks for the multiply/divide unit
// Assumes: One clock domain, asynchronous active-low reset
// Notes: Busy length is counted in helper logic, not by repetition
`timescale 1ns/1ps
`default_nettype none

module mdu_unit_assertions (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Watched ports
    input wire mdu_pkg::mdu_sfr_req_t sfr_req,
    input wire logic [7:0] sfr_rdata_ff,
    input wire logic busy_ff,
    input wire logic access_error_flag_ff,
    input wire logic overflow_flag_ff
);
    logic [4:0] busy_cnt_ff;
    logic opr_acc;

    assign opr_acc = (sfr_req.wr || sfr_req.rd) && (sfr_req.sel <= mdu_pkg::SEL_OPR5);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_cnt_ff <= 5'h00;
        end else begin
            busy_cnt_ff <= busy_ff ? busy_cnt_ff + 5'h01 : 5'h00;
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    AST_START_ON_R5: assert property ($rose(busy_ff) |->
        $past(sfr_req.wr) && $past(sfr_req.sel) == mdu_pkg::SEL_OPR5)
        else $error("busy rose without a register five write");
    AST_BUSY_LEN: assert property ($fell(busy_ff) |->
        busy_cnt_ff inside {5'h09, 5'h0b, 5'h11})
        else $error("calculation time not 9, 11 or 17 cycles");
    AST_BUSY_MAX: assert property (busy_ff |-> busy_cnt_ff < 5'h11)
        else $error("calculation runs past 17 cycles");
    AST_ERR_SET: assert property (busy_ff && opr_acc |=> access_error_flag_ff)
        else $error("operand access while busy did not set error");
    AST_ERR_CAUSE: assert property ($rose(access_error_flag_ff) |->
        $past(busy_ff) && $past(opr_acc))
        else $error("error flag set without a busy access");
    AST_ERR_CLR: assert property (!busy_ff && sfr_req.rd &&
        sfr_req.sel == mdu_pkg::SEL_STAT |=> !access_error_flag_ff)
        else $error("status read after completion left error set");
    AST_OVF_AT_END: assert property (!$stable(overflow_flag_ff) |-> $fell(busy_ff))
        else $error("overflow changed outside the end of a calculation");
    AST_STAT_READ: assert property (sfr_req.rd && sfr_req.sel == mdu_pkg::SEL_STAT |=>
        sfr_rdata_ff == {$past(access_error_flag_ff), $past(overflow_flag_ff), 6'h00})
        else $error("status read data does not match the flags");
    AST_RDATA_HOLD: assert property (!$past(sfr_req.rd) |-> $stable(sfr_rdata_ff))
        else $error("read data changed without a read");
endmodule : mdu_unit_assertions

bind mdu_unit mdu_unit_assertions u_chk (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .sfr_req(sfr_req),
    .sfr_rdata_ff(sfr_rdata_ff),
    .busy_ff(busy_ff),
    .access_error_flag_ff(access_error_flag_ff),
    .overflow_flag_ff(overflow_flag_ff)
);

`default_nettype wire

// File: tb/multiply_divide_unit_bench.sv
// Purpose: Self-checking bench for the multiply/divide unit
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Every access is followed by one idle cycle
`timescale 1ns/1ps
`default_nettype none

module multiply_divide_unit_bench;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    mdu_pkg::mdu_sfr_req_t sfr_req = '0;
    logic [7:0] sfr_rdata_ff;
    logic busy_ff;
    logic access_error_flag_ff;
    logic overflow_flag_ff;
    int fails = 0;
    int samples_checked = 0;
    int cycles = 0;

    always #2.5 core_clk = ~core_clk;

    mdu_unit u_dut (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .sfr_req(sfr_req),
        .sfr_rdata_ff(sfr_rdata_ff),
        .busy_ff(busy_ff),
        .access_error_flag_ff(access_error_flag_ff),
        .overflow_flag_ff(overflow_flag_ff)
    );

    task automatic report_and_stop();
        if (fails == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : report_and_stop

    // The whole run needs well under a thousand cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 2000) begin
            fails++;
            report_and_stop();
        end
    end

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic acc(input logic w, input logic r, input logic [2:0] s, input logic [7:0] d);
        sfr_req = '{wr: w, rd: r, sel: s, wdata: d};
        @(posedge core_clk);
        #1;
        sfr_req = '0;
        @(posedge core_clk);
        #1;
    endtask : acc

    task automatic rdc(input string nm, input logic [2:0] s, input logic [7:0] exp);
        acc(1'b0, 1'b1, s, 8'h00);
        chk(nm, sfr_rdata_ff, exp);
    endtask : rdc

    // Order tables pack one 3-bit selector per step, first step lowest
    task automatic run_op(input int op, input logic [31:0] a, input logic [15:0] b,
                          input int n, input logic bad);
        logic [47:0] v;
        logic [47:0] e;
        logic [31:0] q;
        logic [31:0] p;
        logic [15:0] r;
        logic [17:0] ord;
        logic [17:0] rds;
        logic ovf;
        int k;
        int len;
        v = {b, a};
        p = a[15:0] * b;
        ovf = (b == 16'h0000);
        if (b == 16'h0000) begin
            q = (op == 0) ? 32'hffffffff : 32'h0000ffff;
            r = a[15:0];
        end else if (op == 0) begin
            q = a / b;
            r = 16'(a % b);
        end else begin
            q = {16'h0000, a[15:0] / b};
            r = a[15:0] % b;
        end
        e = {r, q};
        ord = (op == 0) ? 18'h2c688 : 18'h00b08;
        rds = ord;
        len = (op == 0) ? 6 : 4;
        if (op == 2) begin
            e = {16'h0000, p};
            ord = 18'h00a60;
            rds = 18'h00688;
            ovf = (p > 32'h0000ffff);
        end
        for (k = 0; k < len; k++) begin
            acc(1'b1, 1'b0, ord[3*k+:3], v[8*ord[3*k+:3]+:8]);
            if (k == 1) acc(1'b0, 1'b1, mdu_pkg::SEL_STAT, 8'h00);
        end
        k = 1;
        while (busy_ff === 1'b1 && k < 40) begin
            if (bad && k == 1) begin
                acc(1'b1, 1'b0, mdu_pkg::SEL_OPR2, 8'h5a);
                acc(1'b0, 1'b1, mdu_pkg::SEL_OPR0, 8'h00);
                k += 4;
            end else begin
                @(posedge core_clk);
                #1;
                k++;
            end
        end
        chk("busy_len", 8'(k), 8'(n));
        chk("err_pin", {7'h00, access_error_flag_ff}, {7'h00, bad});
        chk("ovf_pin", {7'h00, overflow_flag_ff}, {7'h00, ovf});
        rdc("status", mdu_pkg::SEL_STAT, {bad, ovf, 6'h00});
        rdc("status_again", mdu_pkg::SEL_STAT, {1'b0, ovf, 6'h00});
        chk("err_pin_clr", {7'h00, access_error_flag_ff}, 8'h00);
        for (k = 0; k < len; k++) begin
            rdc("result", rds[3*k+:3], e[8*rds[3*k+:3]+:8]);
        end
    endtask : run_op

    task automatic bare_start();
        acc(1'b1, 1'b0, mdu_pkg::SEL_OPR5, 8'h33);
        acc(1'b1, 1'b0, mdu_pkg::SEL_OPR0, 8'h11);
        acc(1'b1, 1'b0, mdu_pkg::SEL_OPR1, 8'h22);
        acc(1'b1, 1'b0, mdu_pkg::SEL_OPR5, 8'h44);
        chk("busy_idle", {7'h00, busy_ff}, 8'h00);
        rdc("reg5_kept", mdu_pkg::SEL_OPR5, 8'h44);
    endtask : bare_start

    initial begin
        int k;
        repeat (10) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        for (k = 0; k < 8; k++) begin
            rdc("reset_value", 3'(k), 8'h00);
        end
        bare_start();
        run_op(2, 32'h00001234, 16'h5678, 11, 1'b0);
        run_op(2, 32'h000000ff, 16'h0100, 11, 1'b1);
        run_op(0, 32'h12345678, 16'h0123, 17, 1'b0);
        run_op(0, 32'h89abcdef, 16'h0000, 17, 1'b1);
        run_op(1, 32'h00009abc, 16'h0000, 9, 1'b0);
        run_op(1, 32'h0000fedc, 16'h0007, 9, 1'b1);
        report_and_stop();
    end
endmodule : multiply_divide_unit_bench

`default_nettype wire
